/* File: bench/swf_can_node.sv */
`timescale 1ns/10ps
module swf_can_node (
    input  wire        ref_clk,
    input  wire        wake_match,
    input  wire        error_count_up,
    input  wire        error_count_down,
    output reg         rx_frame_done,
    output reg         rx_frame_error,
    output reg         rx_fast_frame,
    output reg  [28:0] rx_ident,
    output reg         rx_ext_fmt,
    output reg         rx_remote,
    output reg  [3:0]  rx_dlc,
    output reg  [63:0] rx_payload
);
    reg [2:0] seen;
    initial begin
        rx_frame_done = 1'h0;
        {rx_ext_fmt, rx_remote, rx_frame_error, rx_fast_frame} = 4'h5;
        rx_ident = 29'h0;
        rx_dlc = 4'hF;
        rx_payload = 64'h0;
        seen = 3'h0;
    end
    // One frame per call, answer captured in the single cycle it stands
    task send(input [28:0] id, input [3:0] fl, input [3:0] dl, input [63:0] pl);
        begin
            @(negedge ref_clk);
            {rx_ext_fmt, rx_remote, rx_frame_error, rx_fast_frame} = fl;
            rx_ident = id;
            rx_dlc = dl;
            rx_payload = pl;
            rx_frame_done = 1'h1;
            @(negedge ref_clk);
            rx_frame_done = 1'h0;
            seen = {wake_match, error_count_up, error_count_down};
            // Fields are scrambled so a late read of them cannot pass by luck
            {rx_ext_fmt, rx_remote, rx_frame_error, rx_fast_frame} = ~fl;
            rx_ident = ~id;
            rx_dlc = ~dl;
            rx_payload = ~pl;
        end
    endtask
endmodule // swf_can_node

/* File: bench/swf_config_monitor.sv */
`timescale 1ns/10ps
module swf_config_monitor (
    input wire       ref_clk,
    input wire       rst_n,
    input wire       spi_cs_n,
    input wire       stored_ext_fmt,
    input wire       rx_frame_done,
    input wire       rx_frame_error,
    input wire       rx_fast_frame,
    input wire       rx_ext_fmt,
    input wire       wake_match,
    input wire       error_count_up,
    input wire       error_count_down,
    input wire [2:0] nominal_bit_rate_sel,
    input wire [1:0] fast_rate_ratio_sel,
    input wire       fast_frame_passive
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_counted;
        error_count_up && !error_count_down && !wake_match;
    endsequence
    sequence s_good;
        rx_frame_done && !rx_frame_error && !rx_fast_frame;
    endsequence
    AST_FD_COUNTED: assert property (rx_frame_done && rx_fast_frame && !fast_frame_passive |=> s_counted)
        else $error("fast frame not counted");
    AST_FD_PASSIVE: assert property (rx_frame_done && rx_fast_frame && fast_frame_passive && !rx_frame_error
        |=> !error_count_up && !error_count_down)
        else $error("passive fast frame moved counter");
    AST_ERR_UP: assert property (rx_frame_done && rx_frame_error && !(rx_fast_frame && fast_frame_passive)
        |=> s_counted)
        else $error("error frame not counted");
    AST_GOOD_DOWN: assert property (s_good |=> error_count_down && !error_count_up)
        else $error("good frame not counted down");
    AST_IDLE: assert property (!rx_frame_done |=> !wake_match && !error_count_up && !error_count_down)
        else $error("pulse without frame");
    AST_FMT: assert property (rx_frame_done && rx_ext_fmt != stored_ext_fmt |=> !wake_match)
        else $error("wake on format mismatch");
    AST_RST_CFG: assert property ($rose(rst_n) |-> nominal_bit_rate_sel == 3'h5 && fast_rate_ratio_sel == 2'h0)
        else $error("rate fields wrong after reset");
    AST_CFG_HOLD: assert property ($changed(nominal_bit_rate_sel) |-> $past(spi_cs_n) == 1'h0)
        else $error("rate changed while deselected");
endmodule // swf_config_monitor
bind swf_config swf_config_monitor u_swf_config_monitor (.ref_clk, .rst_n, .spi_cs_n, .stored_ext_fmt,
    .rx_frame_done, .rx_frame_error, .rx_fast_frame, .rx_ext_fmt, .wake_match, .error_count_up,
    .error_count_down, .nominal_bit_rate_sel, .fast_rate_ratio_sel, .fast_frame_passive);

/* File: bench/tb.sv */
`timescale 1ns/10ps
module tb;
    localparam [28:0] SID = 29'h1ABCDE12;
    reg         ref_clk, rst_n, spi_sclk, spi_cs_n, spi_sdi, stored_ext_fmt;
    reg  [28:0] stored_ident;
    reg  [9:0]  ext_ident_mask_mid;
    reg  [7:0]  rd, v;
    integer     bad_count, samples_checked, i, k;
    wire        spi_sdo, spi_sdo_oe, rx_frame_done, rx_frame_error, rx_fast_frame, rx_ext_fmt, rx_remote;
    wire        wake_match, error_count_up, error_count_down, fast_frame_passive;
    wire [28:0] rx_ident;
    wire [63:0] rx_payload;
    wire [3:0]  rx_dlc;
    wire [2:0]  nominal_bit_rate_sel;
    wire [1:0]  fast_rate_ratio_sel;
    swf_config u_swf_config (.ref_clk, .rst_n, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe,
        .stored_ident, .stored_ext_fmt, .ext_ident_mask_mid, .rx_frame_done, .rx_frame_error, .rx_fast_frame,
        .rx_ident, .rx_ext_fmt, .rx_remote, .rx_dlc, .rx_payload, .wake_match, .error_count_up,
        .error_count_down, .nominal_bit_rate_sel, .fast_rate_ratio_sel, .fast_frame_passive);
    swf_can_node u_swf_can_node (.ref_clk, .wake_match, .error_count_up, .error_count_down, .rx_frame_done,
        .rx_frame_error, .rx_fast_frame, .rx_ident, .rx_ext_fmt, .rx_remote, .rx_dlc, .rx_payload);
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    task chk(input [7:0] got, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        begin
            if (bad_count == 0 && samples_checked > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask
    // Slow sclk phases: the port oversamples sclk, so each level must last several cycles
    task spi(input [6:0] a, input w, input [7:0] wd);
        reg [15:0] sh;
        begin
            sh = {a, w, wd};
            @(negedge ref_clk);
            spi_cs_n = 1'h0;
            for (k = 15; k >= 0; k = k - 1) begin
                spi_sdi = sh[k];
                repeat (4) @(negedge ref_clk);
                if (k < 8) rd[k] = spi_sdo;
                spi_sclk = 1'h1;
                repeat (3) @(negedge ref_clk);
                spi_sclk = 1'h0;
            end
            repeat (3) @(negedge ref_clk);
            spi_cs_n = 1'h1;
        end
    endtask
    task fr(input [28:0] id, input [3:0] fl, input [3:0] dl, input [15:0] pl, input [2:0] ex);
        begin
            u_swf_can_node.send(id, fl, dl, {pl, 48'h0});
            chk({5'h0, u_swf_can_node.seen}, {5'h0, ex});
        end
    endtask
    task t_regs;
        begin
            for (i = 8'h36; i <= 8'h45; i = i + 1) begin
                spi(i[6:0], 1'h0, 8'h00);
                chk(rd, (i == 8'h44) ? 8'h50 : 8'h00);
                spi(i[6:0], 1'h1, i[7:0] ^ 8'h5A);
            end
            for (i = 8'h36; i <= 8'h45; i = i + 1) begin
                v = i[7:0] ^ 8'h5A;
                spi(i[6:0], 1'h0, 8'h00);
                chk(rd, (i == 8'h44) ? v & 8'hFC : (i > 8'h40) ? 8'h00 : v);
            end
        end
    endtask
    task t_rates;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                v = {i[1], i[2:0], 1'h0, i[0], 2'h3};
                spi(7'h44, 1'h1, v);
                chk({2'h0, nominal_bit_rate_sel, fast_rate_ratio_sel, fast_frame_passive},
                    {2'h0, i[2:0], 1'h0, i[0], i[1]});
            end
        end
    endtask
    task t_ident;
        begin
            spi(7'h36, 1'h1, 8'h00);
            spi(7'h37, 1'h1, 8'h00);
            spi(7'h38, 1'h1, 8'h00);
            spi(7'h44, 1'h1, 8'h50);
            fr(SID, 4'h8, 4'h0, 16'h0, 3'h5);
            fr(SID ^ 29'h1, 4'h8, 4'h0, 16'h0, 3'h1);
            spi(7'h36, 1'h1, 8'h01);
            fr(SID ^ 29'h1, 4'h8, 4'h0, 16'h0, 3'h5);
            spi(7'h37, 1'h1, 8'h80);
            fr(SID ^ 29'h10000000, 4'h8, 4'h0, 16'h0, 3'h5);
            fr(SID ^ 29'h40000, 4'h8, 4'h0, 16'h0, 3'h1);
            spi(7'h38, 1'h1, 8'h20);
            fr(SID ^ 29'h40000, 4'h8, 4'h0, 16'h0, 3'h5);
            ext_ident_mask_mid = 10'h001;
            fr(SID ^ 29'h100, 4'h8, 4'h0, 16'h0, 3'h5);
            fr(SID, 4'h0, 4'h0, 16'h0, 3'h1);
            fr(SID, 4'hC, 4'h0, 16'h0, 3'h5);
            stored_ext_fmt = 1'h0;
            fr(SID ^ 29'h3FFFF, 4'h0, 4'h0, 16'h0, 3'h5);
            stored_ext_fmt = 1'h1;
        end
    endtask
    task t_data;
        begin
            spi(7'h39, 1'h1, 8'h81);
            spi(7'h3A, 1'h1, 8'h00);
            spi(7'h38, 1'h1, 8'h05);
            fr(SID, 4'h8, 4'h2, 16'h0100, 3'h5);
            fr(SID, 4'h8, 4'h2, 16'h7EFF, 3'h1);
            fr(SID, 4'h8, 4'h3, 16'h8100, 3'h1);
            fr(SID, 4'hC, 4'h2, 16'h8100, 3'h1);
            spi(7'h38, 1'h1, 8'h04);
            fr(SID, 4'h8, 4'h3, 16'h0000, 3'h5);
            fr(SID, 4'h9, 4'h0, 16'h0, 3'h2);
            spi(7'h44, 1'h1, 8'hD0);
            fr(SID, 4'h9, 4'h0, 16'h0, 3'h0);
            fr(SID, 4'hA, 4'h0, 16'h0, 3'h2);
            fr(SID, 4'h8, 4'h0, 16'h0, 3'h5);
        end
    endtask
    initial begin
        rst_n = 1'h0;
        spi_sclk = 1'h0;
        spi_cs_n = 1'h1;
        spi_sdi = 1'h0;
        stored_ident = SID;
        stored_ext_fmt = 1'h1;
        ext_ident_mask_mid = 10'h000;
        bad_count = 0;
        samples_checked = 0;
        repeat (16) @(negedge ref_clk);
        rst_n = 1'h1;
        t_regs;
        t_rates;
        t_ident;
        t_data;
        finish_test;
    end
endmodule // tb

/* File: src/swf_config.v */
`timescale 1ns/10ps
`include "swf_regs.vh"

// How it works
// - Read/write byte masks extended identifier bits seven down to zero.
// - Read/write byte masks base identifier bits ten to three.
// - Base identifier mask bits two to zero sit in bits seven to five.
// - Compare on: length must equal stored, data hits on set bit, remote frames rejected.
// - Compare off: length and data assumed valid, remote frames accepted.
// - Eight expected data bytes at consecutive addresses, reset to zero.
// - Three addresses after data bytes are reserved, read zero.
// - Passive clear counts fast frames as errors; passive set ignores them.
// - Two-bit fast-phase ratio field, reset to up-to-four-times.
// - Format bit picks 11-bit standard or 29-bit extended comparison.
// - Passive mode: fast frames neither raise nor lower the error counter.

module swf_config (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        spi_sclk,
    input  wire        spi_cs_n,
    input  wire        spi_sdi,
    output reg         spi_sdo,
    output reg         spi_sdo_oe,
    input  wire [28:0] stored_ident,
    input  wire        stored_ext_fmt,
    input  wire [9:0]  ext_ident_mask_mid,
    input  wire        rx_frame_done,
    input  wire        rx_frame_error,
    input  wire        rx_fast_frame,
    input  wire [28:0] rx_ident,
    input  wire        rx_ext_fmt,
    input  wire        rx_remote,
    input  wire [3:0]  rx_dlc,
    input  wire [63:0] rx_payload,
    output reg         wake_match,
    output reg         error_count_up,
    output reg         error_count_down,
    output reg  [2:0]  nominal_bit_rate_sel,
    output reg  [1:0]  fast_rate_ratio_sel,
    output reg         fast_frame_passive
);

    localparam ST_IDLE = 3'b001;
    localparam ST_CMD  = 3'b010;
    localparam ST_DATA = 3'b100;

    reg [7:0]  ext_ident_mask_low;
    reg [7:0]  base_ident_mask_high;
    reg [2:0]  base_ident_mask_low;
    reg [3:0]  expected_dlc;
    reg        data_compare_en;
    reg [7:0]  expected_payload_byte [0:7];

    reg [2:0]  state;
    reg [2:0]  next_state;
    reg        sclk_q;
    reg [2:0]  bit_cnt;
    reg [7:0]  shift_in;
    reg [7:0]  shift_out;
    reg [6:0]  cur_addr;
    reg        cur_write;

    wire        sclk_rise;
    wire        sclk_fall;
    wire        byte_done;
    wire [7:0]  byte_in;
    wire [28:0] ident_mask;
    wire [63:0] expected_payload;
    wire        ident_hit;
    wire        payload_hit;
    wire        fast_err;
    wire        ignored;
    wire        do_write;
    wire [7:0]  read_data_cmd;
    wire [7:0]  read_data_next;
    wire [6:0]  next_addr;

    integer i;

    // Read-back of one address; unmapped and reserved addresses give zero
    function [7:0] swf_read;
        input [6:0] addr;
        begin
            swf_read = 8'h00;
            if (addr == `SWF_OFS_EXT_MASK_LOW) begin
                swf_read = ext_ident_mask_low;
            end else if (addr == `SWF_OFS_BASE_MASK_HIGH) begin
                swf_read = base_ident_mask_high;
            end else if (addr == `SWF_OFS_MASK_LOW_DLC) begin
                swf_read = {base_ident_mask_low, expected_dlc, data_compare_en};
            end else if (addr >= `SWF_OFS_DATA_FIRST && addr <= `SWF_OFS_DATA_LAST) begin
                swf_read = expected_payload_byte[addr[2:0] - 3'h1];
            end else if (addr >= `SWF_OFS_RSVD_FIRST && addr <= `SWF_OFS_RSVD_LAST) begin
                swf_read = 8'h00;
            end else if (addr == `SWF_OFS_RATE_CFG) begin
                swf_read = {fast_frame_passive, nominal_bit_rate_sel, fast_rate_ratio_sel, 2'h0};
            end
        end
    endfunction

    assign sclk_rise = spi_sclk & ~sclk_q;
    assign sclk_fall = ~spi_sclk & sclk_q;
    assign byte_done = sclk_rise && (bit_cnt == `SWF_BITS_PER_BYTE);
    assign byte_in   = {shift_in[6:0], spi_sdi};
    assign do_write  = (state == ST_DATA) && byte_done && cur_write && !spi_cs_n;
    assign next_addr = cur_addr + 7'h01;
    assign read_data_cmd  = swf_read(byte_in[7:1]);
    assign read_data_next = swf_read(next_addr);

    // Mask bits 17:8 live in registers outside this block
    assign ident_mask = {base_ident_mask_high, base_ident_mask_low, ext_ident_mask_mid,
                         ext_ident_mask_low};

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pay
            // Byte 0 of the frame is the first on the wire and sits in the top lane
            assign expected_payload[63-8*g:56-8*g] = expected_payload_byte[g];
        end
    endgenerate

    swf_match u_match (
        .stored_ident     (stored_ident),
        .stored_ext_fmt   (stored_ext_fmt),
        .ident_mask       (ident_mask),
        .rx_ident         (rx_ident),
        .rx_ext_fmt       (rx_ext_fmt),
        .rx_remote        (rx_remote),
        .rx_dlc           (rx_dlc),
        .rx_payload       (rx_payload),
        .expected_dlc     (expected_dlc),
        .expected_payload (expected_payload),
        .data_compare_en  (data_compare_en),
        .ident_hit        (ident_hit),
        .payload_hit      (payload_hit)
    );

    // Serial framing state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (!spi_cs_n) begin
                    next_state = ST_CMD;
                end
            end
            ST_CMD: begin
                if (spi_cs_n) begin
                    next_state = ST_IDLE;
                end else if (byte_done) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (spi_cs_n) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= ST_IDLE;
            sclk_q     <= 1'b0;
            bit_cnt    <= 3'h0;
            shift_in   <= 8'h00;
            shift_out  <= 8'h00;
            cur_addr   <= 7'h00;
            cur_write  <= 1'b0;
            spi_sdo    <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else begin
            state      <= next_state;
            sclk_q     <= spi_sclk;
            spi_sdo_oe <= !spi_cs_n;
            if (spi_cs_n || state == ST_IDLE) begin
                // Dropping select mid-byte abandons the byte, so no partial write lands
                bit_cnt   <= 3'h0;
                shift_in  <= 8'h00;
                shift_out <= 8'h00;
                spi_sdo   <= 1'b0;
            end else begin
                if (sclk_rise) begin
                    bit_cnt  <= bit_cnt + 3'h1;
                    shift_in <= byte_in;
                end
                if (byte_done && state == ST_CMD) begin
                    cur_addr  <= byte_in[7:1];
                    cur_write <= byte_in[`SWF_CMD_WRITE_BIT];
                    shift_out <= {read_data_cmd[6:0], 1'b0};
                    spi_sdo   <= read_data_cmd[7];
                end else if (byte_done && state == ST_DATA) begin
                    // Further bytes in one select walk up through the map
                    cur_addr  <= next_addr;
                    shift_out <= {read_data_next[6:0], 1'b0};
                    spi_sdo   <= read_data_next[7];
                end else if (sclk_fall && state == ST_DATA && bit_cnt != 3'h0) begin
                    spi_sdo   <= shift_out[7];
                    shift_out <= {shift_out[6:0], 1'b0};
                end
            end
        end
    end

    // Register writes; reserved addresses and bits take nothing
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_ident_mask_low   <= `SWF_RST_EXT_MASK_LOW;
            base_ident_mask_high <= `SWF_RST_BASE_MASK_HIGH;
            base_ident_mask_low  <= `SWF_RST_BASE_MASK_LOW;
            expected_dlc         <= `SWF_RST_DLC;
            data_compare_en      <= `SWF_RST_CMP_EN;
            fast_frame_passive   <= `SWF_RST_PASSIVE;
            nominal_bit_rate_sel <= `SWF_RST_NOM_RATE;
            fast_rate_ratio_sel  <= `SWF_RST_FAST_RATIO;
            for (i = 0; i < 8; i = i + 1) begin
                expected_payload_byte[i] <= `SWF_RST_DATA;
            end
        end else if (do_write) begin
            if (cur_addr == `SWF_OFS_EXT_MASK_LOW) begin
                ext_ident_mask_low <= byte_in;
            end
            if (cur_addr == `SWF_OFS_BASE_MASK_HIGH) begin
                base_ident_mask_high <= byte_in;
            end
            if (cur_addr == `SWF_OFS_MASK_LOW_DLC) begin
                base_ident_mask_low <= byte_in[`SWF_MLD_MASK_MSB:`SWF_MLD_MASK_LSB];
                expected_dlc        <= byte_in[`SWF_MLD_DLC_MSB:`SWF_MLD_DLC_LSB];
                data_compare_en     <= byte_in[`SWF_MLD_CMP_BIT];
            end
            if (cur_addr >= `SWF_OFS_DATA_FIRST && cur_addr <= `SWF_OFS_DATA_LAST) begin
                expected_payload_byte[cur_addr[2:0] - 3'h1] <= byte_in;
            end
            if (cur_addr == `SWF_OFS_RATE_CFG) begin
                fast_frame_passive   <= byte_in[`SWF_CFG_PASSIVE_BIT];
                // Reserved rate codes are stored as written; the rate logic must not use them
                nominal_bit_rate_sel <= byte_in[`SWF_CFG_NOM_MSB:`SWF_CFG_NOM_LSB];
                fast_rate_ratio_sel  <= byte_in[`SWF_CFG_RATIO_MSB:`SWF_CFG_RATIO_LSB];
            end
        end
    end

    // Fast frame while not passive counts as an error frame
    assign fast_err = rx_fast_frame && !fast_frame_passive;
    // Fast frame while passive leaves the counter alone
    assign ignored  = rx_fast_frame && fast_frame_passive;

    // Frame results, one-cycle pulses a cycle after the frame ends
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_match       <= 1'b0;
            error_count_up   <= 1'b0;
            error_count_down <= 1'b0;
        end else begin
            wake_match       <= rx_frame_done && !rx_frame_error && !rx_fast_frame &&
                                ident_hit && payload_hit;
            error_count_up   <= rx_frame_done && !ignored && (rx_frame_error || fast_err);
            error_count_down <= rx_frame_done && !rx_frame_error && !rx_fast_frame;
        end
    end

endmodule // swf_config

/* File: src/swf_match.v */
`timescale 1ns/10ps
`include "swf_regs.vh"

module swf_match (
    input  wire [28:0] stored_ident,
    input  wire        stored_ext_fmt,
    input  wire [28:0] ident_mask,
    input  wire [28:0] rx_ident,
    input  wire        rx_ext_fmt,
    input  wire        rx_remote,
    input  wire [3:0]  rx_dlc,
    input  wire [63:0] rx_payload,
    input  wire [3:0]  expected_dlc,
    input  wire [63:0] expected_payload,
    input  wire        data_compare_en,
    output wire        ident_hit,
    output wire        payload_hit
);

    wire [28:0] bit_ok;
    wire [28:0] fmt_bits;
    wire [63:0] lane_sel;
    wire [3:0]  byte_cnt;
    wire        data_ok;

    // Set mask bit is don't-care; unmasked bit must equal stored one
    assign bit_ok   = ident_mask | ~(rx_ident ^ stored_ident);
    // Standard format only looks at the eleven base bits
    assign fmt_bits = stored_ext_fmt ? 29'h1FFFFFFF : 29'h1FFC0000;
    assign ident_hit = (rx_ext_fmt == stored_ext_fmt) && (&(bit_ok | ~fmt_bits));

    // Codes above eight still carry eight payload bytes on classic frames
    assign byte_cnt = (rx_dlc > 4'h8) ? 4'h8 : rx_dlc;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_lane
            // Byte 0 arrives first and sits in the top lane, as the expected bytes do
            assign lane_sel[63-8*g:56-8*g] = (byte_cnt > g) ? 8'hFF : 8'h00;
        end
    endgenerate

    // Any expected bit seen set in a present byte is a hit
    assign data_ok = (byte_cnt == 4'h0) || (|(rx_payload & expected_payload & lane_sel));

    assign payload_hit = data_compare_en ?
                         (!rx_remote && (rx_dlc == expected_dlc) && data_ok) :
                         1'b1;

endmodule // swf_match

/* File: src/swf_regs.vh */
`ifndef SWF_REGS_VH
`define SWF_REGS_VH

// Register offsets on the serial port
`define SWF_OFS_EXT_MASK_LOW     7'h36
`define SWF_OFS_BASE_MASK_HIGH   7'h37
`define SWF_OFS_MASK_LOW_DLC     7'h38
`define SWF_OFS_DATA_FIRST       7'h39
`define SWF_OFS_DATA_LAST        7'h40
`define SWF_OFS_RSVD_FIRST       7'h41
`define SWF_OFS_RSVD_LAST        7'h43
`define SWF_OFS_RATE_CFG         7'h44

// Reset values
`define SWF_RST_EXT_MASK_LOW     8'h00
`define SWF_RST_BASE_MASK_HIGH   8'h00
`define SWF_RST_MASK_LOW_DLC     8'h00
`define SWF_RST_DATA             8'h00
`define SWF_RST_RATE_CFG         8'h50
`define SWF_RST_BASE_MASK_LOW    3'h0
`define SWF_RST_DLC              4'h0
`define SWF_RST_CMP_EN           1'h0
`define SWF_RST_PASSIVE          1'h0
`define SWF_RST_NOM_RATE         3'h5
`define SWF_RST_FAST_RATIO       2'h0

// Field positions in the mask/length/compare register
`define SWF_MLD_MASK_MSB         7
`define SWF_MLD_MASK_LSB         5
`define SWF_MLD_DLC_MSB          4
`define SWF_MLD_DLC_LSB          1
`define SWF_MLD_CMP_BIT          0

// Field positions in the rate/behaviour register
`define SWF_CFG_PASSIVE_BIT      7
`define SWF_CFG_NOM_MSB          6
`define SWF_CFG_NOM_LSB          4
`define SWF_CFG_RATIO_MSB        3
`define SWF_CFG_RATIO_LSB        2

// Nominal rate codes
`define SWF_NOM_50K              3'h0
`define SWF_NOM_100K             3'h1
`define SWF_NOM_125K             3'h2
`define SWF_NOM_250K             3'h3
`define SWF_NOM_RSVD_A           3'h4
`define SWF_NOM_500K             3'h5
`define SWF_NOM_RSVD_B           3'h6
`define SWF_NOM_1M               3'h7

// Fast-phase ratio codes
`define SWF_RATIO_UP_TO_4X       2'h0
`define SWF_RATIO_5X_TO_10X      2'h1

// Serial frame: command byte is address in 7:1, write flag in bit 0
`define SWF_CMD_WRITE_BIT        0
`define SWF_BITS_PER_BYTE        3'h7

`endif
